/* File: hw/baud_tick_gen.sv */
// bit rate source: timer 1 in its modes plus the fixed clock divider for serial mode 2
// assumes: run, mode, reload and double come from registers on the same clock
`timescale 1ns/1ps
`include "serial_port_cfg.svh"
module baud_tick_gen (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // settings
   input wire logic timer1_run_bit,
   input wire logic [1:0] timer1_mode,
   input wire logic [7:0] timer1_reload_byte,
   input wire logic double_rate_bit,
   input wire serial_port_pkg::ser_mode_t ser_mode,
   input wire logic [7:0] low_wdata,
   input wire logic low_we,
   // outputs
   output logic [7:0] timer1_low,
   output logic sample_tick
);

   typedef struct packed {
      logic [7:0] low;
      logic half;
      logic [1:0] div;
      logic tick;
   } baud_state_t;

   baud_state_t state_reg, state_next;
   logic ovf;

   assign timer1_low = state_reg.low;
   assign sample_tick = state_reg.tick;

   // timer 1 counter, overflow pulses, and the rate pick
   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      ovf = 1'b0;
      if (timer1_run_bit && timer1_mode != 2'b11) begin
         if (state_reg.low == 8'hFF) begin
            ovf = 1'b1;
            state_next.low = (timer1_mode == 2'b10) ? timer1_reload_byte : 8'h00;
         end else begin
            state_next.low = state_reg.low + 8'h01;
         end
      end
      // software write wins over counting
      if (low_we) begin
         state_next.low = low_wdata;
      end
      state_next.div = state_reg.div + 2'h1;
      if (ser_mode == serial_port_pkg::SER_9BIT_FIXED) begin
         state_next.tick = double_rate_bit ? state_reg.div[0] : (state_reg.div == 2'h3);
      end else if (ovf) begin
         state_next.half = ~state_reg.half;
         state_next.tick = double_rate_bit | state_reg.half;
      end
   end

   // registered state, frozen while the enable is low
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

endmodule

/* File: hw/serial_port_baud_timer.sv */
// top of the serial port: register port, line synchroniser, flags and interrupt request
// assumes: one 100 MHz clock; software on the register port; remote device on the line
`timescale 1ns/1ps
`include "serial_port_cfg.svh"
module serial_port_baud_timer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // register port
   input wire serial_port_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // serial interrupt enable from the interrupt controller
   input wire logic serial_irq_enable,
   output logic serial_irq,
   // line
   input wire logic rx_pin,
   output logic tx_pin
);

   typedef struct packed {
      logic [7:0] power_control;
      logic [7:0] timer_mode;
      logic [7:0] serial_control;
      logic [7:0] timer_control;
      logic [7:0] timer1_reload_byte;
      logic [7:0] rx_data;
      logic [7:0] tx_data;
      logic tx_start;
      logic [1:0] rx_sync;
      logic [7:0] rdata;
   } top_state_t;

   top_state_t state_reg, state_next;
   serial_port_pkg::ser_mode_t ser_mode;
   serial_port_pkg::frame_t rx_frame;
   logic [7:0] timer1_low;
   logic tick;
   logic tx_done;
   logic rx_done;
   logic nine_bit;
   logic accept;
   logic wr_serial_control;
   logic line_out;

   assign ser_mode = serial_port_pkg::ser_mode_t'({state_reg.serial_control[`SC_MODE_HI],
                                                  state_reg.serial_control[`SC_MODE_LO]});
   assign nine_bit = ser_mode[1];
   assign wr_serial_control = reg_req.wr && reg_req.addr == `ADDR_SERIAL_CONTROL;
   // multiprocessor filter on the ninth bit
   assign accept = !(nine_bit && state_reg.serial_control[`SC_MULTI] && !rx_frame.bit8);
   assign reg_rdata = state_reg.rdata;
   assign tx_pin = state_reg.tx_start ? 1'b1 : line_out;
   assign serial_irq = serial_irq_enable &&
                       (state_reg.serial_control[`SC_TI] || state_reg.serial_control[`SC_RI]);

   // timer 1 and the rate pick
   baud_tick_gen u_baud (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .timer1_run_bit(state_reg.timer_control[`TC_RUN1]),
      .timer1_mode({state_reg.timer_mode[`TM_T1_MODE_HI], state_reg.timer_mode[`TM_T1_MODE_LO]}),
      .timer1_reload_byte(state_reg.timer1_reload_byte),
      .double_rate_bit(state_reg.power_control[`PC_DOUBLE]),
      .ser_mode(ser_mode),
      .low_wdata(reg_req.wdata),
      .low_we(reg_req.wr && reg_req.addr == `ADDR_TIMER1_LOW),
      .timer1_low(timer1_low),
      .sample_tick(tick)
   );

   // shifters, fed from the second synchroniser stage only
   serial_shift_engine u_shift (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tick(tick),
      .nine_bit(nine_bit),
      .rx_enable(state_reg.serial_control[`SC_RX_EN]),
      .tx_start(state_reg.tx_start),
      .tx_frame({state_reg.serial_control[`SC_TB8], state_reg.tx_data}),
      .rx_pin(state_reg.rx_sync[1]),
      .tx_pin(line_out),
      .tx_done(tx_done),
      .rx_done(rx_done),
      .rx_frame(rx_frame)
   );

   // register writes, flag updates and read data
   always_comb begin
      state_next = state_reg;
      state_next.rx_sync = {state_reg.rx_sync[0], rx_pin};
      state_next.tx_start = 1'b0;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            `ADDR_POWER_CONTROL: state_next.power_control = reg_req.wdata;
            // gate, c/t, two mode bits per nibble
            `ADDR_TIMER_MODE: state_next.timer_mode = reg_req.wdata;
            // field order from bit 7 down
            `ADDR_SERIAL_CONTROL: state_next.serial_control = reg_req.wdata;
            `ADDR_TIMER_CONTROL: state_next.timer_control = reg_req.wdata;
            `ADDR_TIMER1_RELOAD: state_next.timer1_reload_byte = reg_req.wdata;
            `ADDR_TX_DATA: begin
               state_next.tx_data = reg_req.wdata;
               state_next.tx_start = 1'b1;
            end
            default: ;
         endcase
      end
      // done-flag sets win over a same-cycle software clear; a same-cycle write wins for receive_bit8
      // transmit done
      if (tx_done) begin
         state_next.serial_control[`SC_TI] = 1'b1;
      end
      // receive done, only for accepted frames
      if (rx_done && accept) begin
         state_next.serial_control[`SC_RI] = 1'b1;
         state_next.rx_data = rx_frame.data;
         if (!wr_serial_control) begin
            state_next.serial_control[`SC_RB8] = rx_frame.bit8;
         end
      end
      state_next.rdata = 8'h00;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `ADDR_POWER_CONTROL: state_next.rdata = state_reg.power_control;
            `ADDR_TIMER_MODE: state_next.rdata = state_reg.timer_mode;
            `ADDR_SERIAL_CONTROL: state_next.rdata = state_reg.serial_control;
            `ADDR_TIMER_CONTROL: state_next.rdata = state_reg.timer_control;
            `ADDR_TIMER1_RELOAD: state_next.rdata = state_reg.timer1_reload_byte;
            `ADDR_TIMER1_LOW: state_next.rdata = timer1_low;
            `ADDR_RX_DATA: state_next.rdata = state_reg.rx_data;
            `ADDR_TX_DATA: state_next.rdata = state_reg.tx_data;
            default: state_next.rdata = 8'h00;
         endcase
      end
   end

   // registered state, frozen while the enable is low
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.rx_sync <= 2'b11;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

endmodule

/* File: hw/serial_port_cfg.svh */
// constants of the serial port with its bit rate timer: offsets, fields, reset values, counts
// assumes: the including file sits in the same folder
// How it works
// - two mode-select bits give serial mode
// - multiprocessor bit drops frames with ninth zero
// - receive only while receive enable set
// - modes 2,3 send transmit_bit8 as ninth
// - modes 2,3 store ninth bit in receive_bit8
// - transmit_done_flag set at frame end
// - receive_done_flag set mid stop bit
// - modes 1,3 rate from timer 1 overflow
// - mode 2 rate quarter or half clock
// - timer mode from two bits, upper first
// - timer_mode holds gate, c/t, mode per timer
// - power_control bit 7 doubles rate
// - serial_control field order as listed
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// register addresses on the plain register port
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_TIMER_MODE 8'h89
`define ADDR_SERIAL_CONTROL 8'h98
`define ADDR_TIMER1_LOW 8'h8B
`define ADDR_TIMER1_RELOAD 8'h8D
`define ADDR_TIMER_CONTROL 8'h88
`define ADDR_RX_DATA 8'h99
`define ADDR_TX_DATA 8'h9A

// serial_control bit positions
`define SC_MODE_HI 7
`define SC_MODE_LO 6
`define SC_MULTI 5
`define SC_RX_EN 4
`define SC_TB8 3
`define SC_RB8 2
`define SC_TI 1
`define SC_RI 0

// power_control double rate bit, timer control run bit, timer_mode fields
`define PC_DOUBLE 7
`define TC_RUN1 6
`define TM_T1_MODE_HI 5
`define TM_T1_MODE_LO 4

// reset values, none being given the registers start clear
`define RESET_BYTE 8'h00

// sampling: each bit time is sixteen ticks, ticks from the rate logic
`define TICKS_PER_BIT 4'hF
`define TICK_MID 4'h7

`endif

/* File: hw/serial_port_pkg.sv */
// types shared by the serial port files
// assumes: compiled before every module of the block
package serial_port_pkg;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // frame as seen by the shift engines: ninth bit and data byte
   typedef struct packed {
      logic bit8;
      logic [7:0] data;
   } frame_t;

   typedef enum logic [1:0] {SER_SHIFT, SER_8BIT, SER_9BIT_FIXED, SER_9BIT_VAR} ser_mode_t;

   typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

/* File: hw/serial_shift_engine.sv */
// transmit and receive shift engines; each bit spans sixteen rate ticks
// assumes: tick from baud_tick_gen, rx_pin already synchronised by the caller
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "serial_port_cfg.svh"
module serial_shift_engine (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // control
   input wire logic tick,
   input wire logic nine_bit,
   input wire logic rx_enable,
   input wire logic tx_start,
   input wire serial_port_pkg::frame_t tx_frame,
   // line
   input wire logic rx_pin,
   output logic tx_pin,
   // results
   output logic tx_done,
   output logic rx_done,
   output serial_port_pkg::frame_t rx_frame
);

   typedef struct packed {
      serial_port_pkg::tx_state_t tx_st;
      logic [9:0] tx_sh;
      logic [3:0] tx_cnt;
      logic [3:0] tx_bits;
      logic tx_line;
      logic tx_done;
      serial_port_pkg::rx_state_t rx_st;
      logic [3:0] rx_cnt;
      logic [3:0] rx_bits;
      logic [8:0] rx_sh;
      logic rx_done;
      serial_port_pkg::frame_t rx_frame;
   } shift_state_t;

   shift_state_t state_reg, state_next;
   logic [3:0] frame_bits;

   assign tx_pin = state_reg.tx_line;
   assign tx_done = state_reg.tx_done;
   assign rx_done = state_reg.rx_done;
   assign rx_frame = state_reg.rx_frame;
   // data bits plus stop after the start bit
   assign frame_bits = nine_bit ? 4'hA : 4'h9;

   // both engines in one pass; they share only the tick and the frame width
   always_comb begin
      state_next = state_reg;
      state_next.tx_done = 1'b0;
      state_next.rx_done = 1'b0;
      unique case (state_reg.tx_st)
         serial_port_pkg::TX_IDLE: begin
            state_next.tx_line = 1'b1;
            if (tx_start) begin
               state_next.tx_sh = {1'b1, tx_frame.bit8, tx_frame.data};
               if (!nine_bit) begin
                  state_next.tx_sh = {2'b11, tx_frame.data};
               end
               state_next.tx_line = 1'b0;
               state_next.tx_cnt = 4'h0;
               state_next.tx_bits = 4'h0;
               state_next.tx_st = serial_port_pkg::TX_SEND;
            end
         end
         serial_port_pkg::TX_SEND: begin
            if (tick) begin
               state_next.tx_cnt = state_reg.tx_cnt + 4'h1;
               if (state_reg.tx_cnt == `TICKS_PER_BIT) begin
                  if (state_reg.tx_bits == frame_bits) begin
                     state_next.tx_st = serial_port_pkg::TX_IDLE;
                     state_next.tx_done = 1'b1;
                  end else begin
                     state_next.tx_line = state_reg.tx_sh[0];
                     state_next.tx_sh = {1'b1, state_reg.tx_sh[9:1]};
                     state_next.tx_bits = state_reg.tx_bits + 4'h1;
                  end
               end
            end
         end
         default: state_next.tx_st = serial_port_pkg::TX_IDLE;
      endcase
      unique case (state_reg.rx_st)
         serial_port_pkg::RX_IDLE: begin
            // only hunt for a start bit when enabled
            if (rx_enable && !rx_pin) begin
               state_next.rx_st = serial_port_pkg::RX_START;
               state_next.rx_cnt = 4'h0;
            end
         end
         serial_port_pkg::RX_START: begin
            if (tick) begin
               state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
               if (state_reg.rx_cnt == `TICK_MID) begin
                  // a glitch shorter than half a bit is not a start
                  state_next.rx_st = rx_pin ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
                  state_next.rx_cnt = 4'h0;
                  state_next.rx_bits = 4'h0;
               end
            end
         end
         serial_port_pkg::RX_DATA: begin
            if (tick) begin
               state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
               if (state_reg.rx_cnt == `TICKS_PER_BIT) begin
                  state_next.rx_sh = {rx_pin, state_reg.rx_sh[8:1]};
                  state_next.rx_bits = state_reg.rx_bits + 4'h1;
                  if (state_reg.rx_bits == frame_bits - 4'h2) begin
                     state_next.rx_st = serial_port_pkg::RX_STOP;
                  end
               end
            end
         end
         serial_port_pkg::RX_STOP: begin
            if (tick) begin
               state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
               if (state_reg.rx_cnt == `TICKS_PER_BIT) begin
                  state_next.rx_st = serial_port_pkg::RX_IDLE;
                  state_next.rx_done = 1'b1;
                  // eight-bit frames: stop bit lands where the ninth would be
                  if (nine_bit) begin
                     state_next.rx_frame = {state_reg.rx_sh[8], state_reg.rx_sh[7:0]};
                  end else begin
                     state_next.rx_frame = {rx_pin, state_reg.rx_sh[8:1]};
                  end
               end
            end
         end
         default: state_next.rx_st = serial_port_pkg::RX_IDLE;
      endcase
   end

   // registered state; idle line is high after reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.tx_line <= 1'b1;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

endmodule

/* File: verification/remote_serial_model.sv */
// remote device on the serial line: sends frames to the port, captures what the port sends
// assumes: idle-high line, bit time in system clocks set by the bench through config_line and kept until changed
`timescale 1ns/1ps
module remote_serial_model (
   // clock
   input wire logic sys_clk,
   // line
   input wire logic line_in,
   output logic line_out
);
   int bit_cyc = 64;
   int n_bits = 9;
   int n_got = 0;
   logic [8:0] got = 9'h000;

   initial line_out = 1'b1;

   // bit time and frame width as the port is set up
   task automatic config_line(input int cyc, input int bits);
      bit_cyc = cyc;
      n_bits = bits;
   endtask

   // start bit, data lsb first, optional ninth bit, stop; entered right after an edge
   task automatic send_frame(input logic [8:0] f);
      line_out <= 1'b0;
      repeat (bit_cyc) @(posedge sys_clk);
      for (int i = 0; i < n_bits; i++) begin
         line_out <= f[i];
         repeat (bit_cyc) @(posedge sys_clk);
      end
      line_out <= 1'b1;
      repeat (bit_cyc) @(posedge sys_clk);
   endtask

   // capture at mid-bit counted from the start edge, so a wrong rate shows as bad data
   always begin
      @(negedge line_in);
      repeat (bit_cyc / 2) @(posedge sys_clk);
      got = 9'h000;
      for (int i = 0; i < n_bits; i++) begin
         repeat (bit_cyc) @(posedge sys_clk);
         got[i] = line_in;
      end
      repeat (bit_cyc) @(posedge sys_clk);
      n_got++;
   end
endmodule

/* File: verification/serial_port_assertions.sv */
// checker of the serial port top: register port answers, sticky flags, interrupt request
// assumes: bound to serial_port_baud_timer, one clock domain, reset active low
`timescale 1ns/1ps
module serial_port_assertions (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // register port
   input wire serial_port_pkg::reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   // interrupt
   input wire logic serial_irq_enable,
   input wire logic serial_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // read of serial_control, used by several checks
   logic sc_rd;
   assign sc_rd = reg_req.rd && reg_req.addr == 8'h98;

   // a write followed by a read of the same place; mask hides hardware-owned bits
   property write_back(logic [7:0] a, logic [7:0] m);
      (reg_req.wr && reg_req.addr == a) ##1 !reg_req.wr ##1 (reg_req.rd && reg_req.addr == a)
         |=> (reg_rdata & m) == ($past(reg_req.wdata, 3) & m);
   endproperty

   read_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
      else $error("read data seen outside a read answer");
   unmapped_read_a: assert property ((reg_req.rd && reg_req.addr < 8'h80) |=>
      reg_rdata == 8'h00) else $error("unmapped read gave nonzero data");
   tmode_back_a: assert property (write_back(8'h89, 8'hFF))
      else $error("timer_mode did not keep written value");
   pctl_back_a: assert property (write_back(8'h87, 8'h80))
      else $error("double rate bit did not keep written value");
   serial_control_back_a: assert property (write_back(8'h98, 8'hF8))
      else $error("serial_control fields did not keep written value");
   // flags stay set until software writes them
   flags_sticky_a: assert property (
      sc_rd ##1 (reg_rdata[1:0] != 2'h0 && !reg_req.wr) ##1 sc_rd
         |=> (reg_rdata[1:0] & $past(reg_rdata[1:0], 2)) == $past(reg_rdata[1:0], 2))
      else $error("done flag dropped without a write");
   irq_gate_a: assert property (!serial_irq_enable |-> !serial_irq)
      else $error("interrupt raised while disabled");
   irq_flag_a: assert property (
      sc_rd ##1 (reg_rdata[1:0] != 2'h0 && serial_irq_enable && !reg_req.wr) |-> serial_irq)
      else $error("flag set and enabled but no interrupt");

   // main scenarios reached
   cover property (sc_rd ##1 reg_rdata[0]);
   cover property (sc_rd ##1 reg_rdata[1]);
   cover property (serial_irq);
endmodule

bind serial_port_baud_timer serial_port_assertions serial_port_assertions_i (
   .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .serial_irq_enable(serial_irq_enable), .serial_irq(serial_irq)
);

/* File: verification/test_serial_port_baud_timer.sv */
// bench of the serial port: register port tasks, remote device model, one task per scenario
// assumes: design package and modules compiled first, then model and checker
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
$display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_serial_port_baud_timer;
   // clock, reset and design signals
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   serial_port_pkg::reg_req_t reg_req = '0;
   logic serial_irq_enable = 1'b0;
   logic [7:0] reg_rdata;
   logic serial_irq;
   logic rx_pin;
   logic tx_pin;
   logic [7:0] rd_val;
   logic irq_val;
   int n_fail = 0;
   int n_tests = 0;

   always #5 sys_clk = ~sys_clk;

   serial_port_baud_timer serial_port_baud_timer_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .serial_irq_enable(serial_irq_enable),
      .serial_irq(serial_irq), .rx_pin(rx_pin), .tx_pin(tx_pin)
   );
   remote_serial_model remote_serial_model_i (
      .sys_clk(sys_clk), .line_in(tx_pin), .line_out(rx_pin)
   );

   // one-cycle write strobe, then an idle cycle
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      reg_req <= '0;
      @(posedge sys_clk);
   endtask

   // data stand only in the cycle after the strobe: sample it mid-cycle
   task automatic reg_rd(input logic [7:0] a);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      reg_req <= '0;
      @(negedge sys_clk);
      rd_val = reg_rdata;
      irq_val = serial_irq;
      @(posedge sys_clk);
   endtask

   task automatic check_regs();
      reg_rd(8'h87);
      `CHK(rd_val, 8'h00)
      reg_rd(8'h89);
      `CHK(rd_val, 8'h00)
      reg_rd(8'h98);
      `CHK(rd_val, 8'h00)
      reg_wr(8'h89, 8'h21);
      reg_rd(8'h89);
      `CHK(rd_val, 8'h21)
      reg_wr(8'h87, 8'h80);
      reg_rd(8'h87);
      `CHK(rd_val[7], 1'b1)
      reg_wr(8'h98, 8'hE8);
      reg_rd(8'h98);
      `CHK(rd_val[7:3], 5'h1D)
      reg_rd(8'h50);
      `CHK(rd_val, 8'h00)
   endtask

   // mode 2 at a quarter of the clock: 16 ticks of 4 cycles per bit
   task automatic check_tx_mode2();
      reg_wr(8'h87, 8'h00);
      reg_wr(8'h98, 8'h88);
      remote_serial_model_i.config_line(64, 9);
      serial_irq_enable <= 1'b1;
      reg_wr(8'h9A, 8'hA5);
      for (int k = 0; k < 2000 && remote_serial_model_i.n_got == 0; k++) @(posedge sys_clk);
      `CHK(remote_serial_model_i.got, 9'h1A5)
      repeat (64) @(posedge sys_clk);
      reg_rd(8'h98);
      `CHK(rd_val[1], 1'b1)
      `CHK(irq_val, 1'b1)
      reg_wr(8'h98, 8'h88);
      reg_rd(8'h98);
      `CHK(irq_val, 1'b0)
      serial_irq_enable <= 1'b0;
   endtask

   // mode 3 from timer 1 with double rate: overflow every 2 cycles, 32 cycles per bit
   task automatic check_rx_mode3();
      // reload two below wrap, factor 2
      // rate from timer 1 in its reload mode
      reg_wr(8'h89, 8'h20);
      reg_wr(8'h8D, 8'hFE);
      reg_wr(8'h8B, 8'hFE);
      reg_wr(8'h88, 8'h40);
      reg_wr(8'h87, 8'h80);
      reg_wr(8'h98, 8'hD0);
      remote_serial_model_i.config_line(32, 9);
      remote_serial_model_i.send_frame(9'h13C);
      reg_rd(8'h98);
      `CHK(rd_val[2:0], 3'h5)
      reg_rd(8'h98);
      `CHK(rd_val[2:0], 3'h5)
      reg_rd(8'h99);
      `CHK(rd_val, 8'h3C)
   endtask

   // half the overflow rate now: a frame with ninth bit clear is dropped
   task automatic check_multiproc();
      reg_wr(8'h87, 8'h00);
      reg_wr(8'h98, 8'hF0);
      remote_serial_model_i.config_line(64, 9);
      remote_serial_model_i.send_frame(9'h055);
      reg_rd(8'h98);
      `CHK(rd_val[0], 1'b0)
      remote_serial_model_i.send_frame(9'h155);
      reg_rd(8'h98);
      `CHK(rd_val[0], 1'b1)
      reg_rd(8'h99);
      `CHK(rd_val, 8'h55)
   endtask

   // receive enable clear: the frame leaves no trace
   task automatic check_rx_off();
      reg_wr(8'h98, 8'hC0);
      remote_serial_model_i.send_frame(9'h1AA);
      reg_rd(8'h98);
      `CHK(rd_val[0], 1'b0)
      reg_rd(8'h99);
      `CHK(rd_val, 8'h55)
   endtask

   // mode 1 frames carry eight data bits only
   task automatic check_mode1();
      reg_wr(8'h98, 8'h50);
      remote_serial_model_i.config_line(64, 8);
      remote_serial_model_i.send_frame(9'h0C3);
      reg_rd(8'h98);
      `CHK(rd_val[0], 1'b1)
      reg_rd(8'h99);
      `CHK(rd_val, 8'hC3)
   endtask

   // timer 1 mode 3 holds its count; a write while the enable is low is lost
   task automatic check_freeze();
      reg_wr(8'h89, 8'h30);
      reg_wr(8'h8B, 8'h10);
      reg_rd(8'h8B);
      `CHK(rd_val, 8'h10)
      clk_en <= 1'b0;
      reg_wr(8'h8D, 8'h00);
      clk_en <= 1'b1;
      reg_rd(8'h8D);
      `CHK(rd_val, 8'hFE)
   endtask

   task automatic give_verdict();
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      check_regs();
      check_tx_mode2();
      check_rx_mode3();
      check_multiproc();
      check_rx_off();
      check_mode1();
      check_freeze();
      give_verdict();
   end

   // watchdog: the scenarios need well under 10000 cycles
   initial begin
      repeat (30000) @(posedge sys_clk);
      n_fail++;
      give_verdict();
   end
endmodule
